//--- core/sicec_core.sv
// System integration counter and exception control, Wishbone slave.
// Assumes a core that signals instruction end and return; one clock.
//
// What this block does
// - 13-bit counter on crystal clock falling edge; overflow clocks watchdog.
// - Bus clocks held off until stabilization delay is counted out.
// - Power-on pulse first; clock generator enabled once the pulse ends, except in stop.
// - Stop instruction clears the counter to zero.
// - Stop exit samples option bit: 32 cycles if one, else 4096.
// - External reset pin does not change the counter.
// - Counter runs freely after any reset state.
// - Core stacks registers and sets mask on entry; return restores.
// - Requests latched at processing start; arbitration yields vector code.
// - Latched request not preempted until serviced or reset.
// - Requests acted on at instruction end if unmasked and enabled.
// - Highest priority first; pending request taken after return.
// - Index-high register not stacked; routines save it themselves.
// - Software interrupt ignores mask, stacks PC not PC minus one.
// - Low pending register holds flags one to six in bits 7..2.
// - Mid pending register holds flags seven to fourteen.
// - High register holds flags fifteen to eighteen in low nibble.
// - Flag reads one while its source requests, fixed source order.
// - Resets share top priority and are never arbitrated.
// - Break request forces the core to the software interrupt vector.
// - Flag clears blocked during break unless break clear enable set.
// - Two-step clears stay protected in break, complete normally after.
`timescale 1ns/10ps
module sicec_core
  import sicec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic xtal_clk_i,
  input wire logic por_pulse_i,
  input wire logic ext_reset_i,
  input wire logic int_reset_i,
  input wire logic wdog_service_i,
  input wire logic stop_exec_i,
  input wire logic insn_end_i,
  input wire logic int_ack_i,
  input wire logic mask_bit_i,
  input wire logic soft_int_i,
  input wire logic break_req_i,
  input wire logic [`SICEC_NSRC-1:0] src_req_i,
  input wire logic [`SICEC_NSRC-1:0] src_en_i,
  input wire logic flag_clear_req_i,
  input wire logic [`SICEC_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic bus_clk_en_o,
  output logic clkgen_en_o,
  output logic wdog_clk_o,
  output logic int_take_o,
  output logic [`SICEC_VEC_W-1:0] vec_code_o,
  output logic stack_pc_minus1_o,
  output logic break_state_o,
  output logic flag_clear_allow_o
);

  sicec_wb_req_t req;
  sicec_vec_t latch_r;
  sicec_pwr_t pwr_r;
  logic [`SICEC_CNT_W-1:0] cnt_r;
  logic [`SICEC_CNT_W-1:0] cnt_nxt;
  logic xclk_r;
  logic xfall;
  logic init_done_r;
  logic short_rec_r;
  logic brk_clr_en_r;
  logic wdog_clk_r;
  logic ack_r;
  logic err_r;
  logic [31:0] rdat_r;
  logic [`SICEC_CNT_W-1:0] rec_target;
  logic [`SICEC_NSRC-1:0] pend;
  logic [`SICEC_VEC_W-1:0] win;
  logic acc;

  // Lowest index wins: flag order doubles as priority
  function automatic logic [`SICEC_VEC_W-1:0] prio(input logic [`SICEC_NSRC-1:0] p);
    logic [`SICEC_VEC_W-1:0] c;
    c = `SICEC_VEC_NONE;
    for (int i = `SICEC_NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        c = `SICEC_VEC_W'(i + 1);
      end
    end
    return c;
  endfunction

  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i,
                 stb: wb_stb_i, cyc: wb_cyc_i};
  // Crystal clock is sampled; a falling edge is a 1->0 of the sample
  assign xfall = xclk_r & ~xtal_clk_i;
  assign pend = src_req_i;
  assign win = prio(src_req_i & src_en_i);
  assign rec_target = short_rec_r ? `SICEC_SHORT_REC : `SICEC_LONG_REC;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      xclk_r <= 1'b0;
    end else begin
      xclk_r <= xtal_clk_i;
    end
  end

  always_comb begin
    cnt_nxt = cnt_r + `SICEC_CNT_W'(1);
  end

  // Counter: cleared by power-on, internal reset and stop; not by the pin
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (por_pulse_i || int_reset_i) begin
      cnt_r <= '0;
    end else if (stop_exec_i || pwr_r == SICEC_STOPPED) begin
      cnt_r <= '0;
    end else if (wdog_service_i) begin
      cnt_r <= cnt_r & `SICEC_WDOG_CLR_MASK;
    end else if (xfall) begin
      cnt_r <= cnt_nxt;
    end
  end

  // Overflow pulse feeds the watchdog prescaler input
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wdog_clk_r <= 1'b0;
    end else begin
      wdog_clk_r <= xfall && (cnt_r == {`SICEC_CNT_W{1'b1}});
    end
  end
  assign wdog_clk_o = wdog_clk_r;

  // Power sequence: power-on waits the long delay, stop waits the selected one
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_r <= SICEC_RECOVER;
    end else if (por_pulse_i) begin
      pwr_r <= SICEC_RECOVER;
    end else begin
      case (pwr_r)
        SICEC_RUN: begin
          if (stop_exec_i) begin
            pwr_r <= SICEC_STOPPED;
          end
        end
        SICEC_STOPPED: begin
          if (|(src_req_i & src_en_i) || break_req_i || ext_reset_i || int_reset_i) begin
            pwr_r <= SICEC_RECOVER;
          end
        end
        SICEC_RECOVER: begin
          if (cnt_r >= (init_done_r ? rec_target : `SICEC_LONG_REC)) begin
            pwr_r <= SICEC_RUN;
          end
        end
        default: pwr_r <= SICEC_RUN;
      endcase
    end
  end

  // Set on first reaching run; until then recovery uses the long delay, after that the option
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      init_done_r <= 1'b0;
    end else if (por_pulse_i) begin
      init_done_r <= 1'b0;
    end else if (pwr_r == SICEC_RUN) begin
      init_done_r <= 1'b1;
    end
  end

  assign bus_clk_en_o = (pwr_r == SICEC_RUN);
  assign clkgen_en_o = ~por_pulse_i & (pwr_r != SICEC_STOPPED);

  // Arbitration latch: held until serviced or reset
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      latch_r <= '{code: `SICEC_VEC_NONE, valid: 1'b0};
    end else if (int_reset_i || ext_reset_i) begin
      latch_r <= '{code: `SICEC_VEC_NONE, valid: 1'b0};
    end else if (latch_r.valid) begin
      if (int_ack_i) begin
        latch_r.valid <= 1'b0;
      end
    end else if (break_req_i || soft_int_i) begin
      latch_r <= '{code: `SICEC_VEC_SOFT, valid: 1'b1};
    end else if (insn_end_i && !mask_bit_i && win != `SICEC_VEC_NONE) begin
      latch_r <= '{code: win, valid: 1'b1};
    end
  end

  assign int_take_o = latch_r.valid;
  assign vec_code_o = latch_r.code;
  assign stack_pc_minus1_o = latch_r.valid && latch_r.code != `SICEC_VEC_SOFT;

  // Break state: entered on break, left once no request is latched and the mask is clear
  logic brk_r;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      brk_r <= 1'b0;
    end else if (break_req_i) begin
      brk_r <= 1'b1;
    end else if (!mask_bit_i && !latch_r.valid) begin
      brk_r <= 1'b0;
    end
  end
  assign break_state_o = brk_r;
  assign flag_clear_allow_o = flag_clear_req_i & (~brk_r | brk_clr_en_r);

  // Software-written option and break control bits
  assign acc = req.cyc & req.stb & ~ack_r & ~err_r;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      brk_clr_en_r <= 1'b0;
      short_rec_r <= 1'b0;
    end else if (acc && req.we && req.sel[0]) begin
      if (req.adr == `SICEC_ADR_BRK_CTRL) begin
        brk_clr_en_r <= req.dat[`SICEC_BRK_CLR_EN_BIT];
      end
      if (req.adr == `SICEC_ADR_OPTION) begin
        short_rec_r <= req.dat[`SICEC_SHORT_REC_BIT];
      end
    end
  end

  // Read mux; pending register writes are accepted and dropped
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      if (acc) begin
        ack_r <= 1'b1;
        rdat_r <= '0;
        case (req.adr)
          `SICEC_ADR_PEND_LOW: rdat_r <= {24'h000000, pend[5:0], 2'h0};
          `SICEC_ADR_PEND_MID: rdat_r <= {24'h000000, pend[13:6]};
          `SICEC_ADR_PEND_HIGH: rdat_r <= {28'h0000000, pend[17:14]};
          `SICEC_ADR_BRK_CTRL: rdat_r <= {24'h000000, brk_clr_en_r, 7'h00};
          `SICEC_ADR_OPTION: rdat_r <= {31'h00000000, short_rec_r};
          `SICEC_ADR_STATUS: rdat_r <= {27'h0000000, brk_r, latch_r.valid, bus_clk_en_o,
                                        pwr_r};
          default: begin
            ack_r <= 1'b0;
            err_r <= 1'b1;
          end
        endcase
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdat_r;

  sequence stop_seen_s;
    stop_exec_i && !por_pulse_i && !int_reset_i;
  endsequence
  sequence cnt_zero_s;
    cnt_r == '0;
  endsequence

  stop_clears_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    stop_seen_s |=> cnt_zero_s) else $error("Stop did not clear counter");
  bus_gated_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    pwr_r != SICEC_RUN |-> !bus_clk_en_o) else $error("Bus clocks on in recovery");
  pin_keep_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ext_reset_i && !xfall && !por_pulse_i && !int_reset_i && !stop_exec_i && !wdog_service_i
    && pwr_r != SICEC_STOPPED |=> cnt_r == $past(cnt_r)) else $error("Pin reset moved counter");
  short_rec_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    pwr_r == SICEC_RECOVER && init_done_r && short_rec_r && cnt_r < `SICEC_SHORT_REC
    |=> pwr_r != SICEC_RUN || $past(por_pulse_i) || $past(cnt_r) >= `SICEC_SHORT_REC)
    else $error("Short recovery ended early");
  hold_latch_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    latch_r.valid && !int_ack_i && !int_reset_i && !ext_reset_i |=> latch_r.valid
    && latch_r.code == $past(latch_r.code)) else $error("Latched request preempted");
  mask_block_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !latch_r.valid && mask_bit_i && !soft_int_i && !break_req_i |=> !latch_r.valid)
    else $error("Masked request taken");
  soft_vec_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !latch_r.valid && soft_int_i && !int_reset_i && !ext_reset_i
    |=> latch_r.valid && !stack_pc_minus1_o) else $error("Software interrupt mishandled");
  brk_protect_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    brk_r && !brk_clr_en_r |-> !flag_clear_allow_o) else $error("Flag cleared in break");
  pend_low_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    acc && req.adr == `SICEC_ADR_PEND_LOW |=> rdat_r[1:0] == 2'h0
    && rdat_r[7:2] == $past(src_req_i[5:0])) else $error("Low pending read wrong");

  // Cycles spent in recovery; saturates so a stuck recovery cannot wrap
  logic [15:0] rec_cyc_r;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rec_cyc_r <= '0;
    end else if (pwr_r != SICEC_RECOVER) begin
      rec_cyc_r <= '0;
    end else if (rec_cyc_r != '1) begin
      rec_cyc_r <= rec_cyc_r + 16'h0001;
    end
  end

  sequence brk_seen_s;
    break_req_i && !latch_r.valid && !int_reset_i && !ext_reset_i;
  endsequence
  sequence soft_latched_s;
    latch_r.valid && latch_r.code == `SICEC_VEC_SOFT;
  endsequence

  long_rec_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    pwr_r == SICEC_RECOVER && !short_rec_r && !por_pulse_i
    |=> pwr_r != SICEC_RUN || rec_cyc_r >= 16'(`SICEC_LONG_REC)) else $error("Recovery too short");

  brk_vector_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    brk_seen_s |=> soft_latched_s ##0 brk_r)
    else $error("Break did not force the soft vector");

  wdog_fire_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    xfall && cnt_r == {`SICEC_CNT_W{1'b1}} |=> wdog_clk_o)
    else $error("Overflow pulse missing");

  wdog_only_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !(xfall && cnt_r == {`SICEC_CNT_W{1'b1}}) |=> !wdog_clk_o)
    else $error("Stray overflow pulse");

  cnt_step_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    xfall && pwr_r != SICEC_STOPPED && !stop_exec_i && !por_pulse_i && !int_reset_i
    && !wdog_service_i |=> cnt_r == $past(cnt_r) + `SICEC_CNT_W'(1)) else $error("Counter stalled");

  stop_zero_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    pwr_r == SICEC_STOPPED |-> cnt_r == '0)
    else $error("Counter moved in stop");

  clkgen_por_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    por_pulse_i |-> !clkgen_en_o)
    else $error("Clock generator on during power-on pulse");

  rst_flush_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ext_reset_i || int_reset_i |=> !latch_r.valid)
    else $error("Reset did not override latch");

  take_open_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !latch_r.valid && insn_end_i && !mask_bit_i && !int_reset_i && !ext_reset_i
    && (src_req_i & src_en_i) != '0 |=> latch_r.valid) else $error("Open request not taken");

  flag_free_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    flag_clear_req_i && (!brk_r || brk_clr_en_r) |-> flag_clear_allow_o)
    else $error("Allowed flag clear blocked");

  pend_ro_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    acc && req.we && req.adr == `SICEC_ADR_PEND_LOW |=> brk_clr_en_r == $past(brk_clr_en_r)
    && short_rec_r == $past(short_rec_r)) else $error("Pending write changed state");

  ack_pulse_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held too long");
endmodule // sicec_core

//--- shared/sicec_cfg.svh
// Constants for the integration counter and exception control block.
// Assumes inclusion by the package and the testbench; definitions only.
`ifndef SICEC_CFG_SVH
`define SICEC_CFG_SVH
`define SICEC_CNT_W 13
`define SICEC_LONG_REC 13'h1000
`define SICEC_SHORT_REC 13'h0020
`define SICEC_WDOG_CLR_MASK 13'h000f
`define SICEC_NSRC 18
`define SICEC_VEC_W 5
`define SICEC_VEC_NONE 5'h1f
`define SICEC_VEC_SOFT 5'h00
`define SICEC_ADDR_W 16
`define SICEC_ADR_PEND_LOW 16'hfe04
`define SICEC_ADR_PEND_MID 16'hfe05
`define SICEC_ADR_PEND_HIGH 16'hfe06
`define SICEC_ADR_BRK_CTRL 16'hfe03
`define SICEC_ADR_OPTION 16'hfe08
`define SICEC_ADR_STATUS 16'hfe09
`define SICEC_BRK_CLR_EN_BIT 7
`define SICEC_SHORT_REC_BIT 0
`endif

//--- shared/sicec_pkg.sv
// Types for the integration counter and exception control block.
// Assumes sicec_cfg.svh is on the include path.
`include "sicec_cfg.svh"
package sicec_pkg;
  typedef enum logic [1:0] {SICEC_RUN, SICEC_STOPPED, SICEC_RECOVER} sicec_pwr_t;
  typedef struct packed {
    logic [`SICEC_ADDR_W-1:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic stb;
    logic cyc;
  } sicec_wb_req_t;
  typedef struct packed {
    logic [`SICEC_VEC_W-1:0] code;
    logic valid;
  } sicec_vec_t;
endpackage

//--- sim/sicec_core_model.sv
// Behavioural processor core facing the exception controller.
// Assumes take_i is the registered latch-valid output; one clock.
`timescale 1ns/10ps
module sicec_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic take_i,
  input wire logic mask_req_i,
  input wire logic [7:0] dly_i,
  output logic ack_o,
  output logic mask_o
);
  logic [7:0] cnt_r;

  // Mask held while servicing, restored on return
  assign mask_o = mask_req_i | take_i;
  // Slow return lets the bench try preemption first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 8'h00;
      ack_o <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (take_i && !ack_o && cnt_r == dly_i) begin
        ack_o <= 1'b1;
        cnt_r <= 8'h00;
      end else if (take_i && !ack_o) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule // sicec_core_model

//--- sim/testbench.sv
// Self-checking bench for the counter and exception control block.
// Assumes the core model answers latched requests; crystal is free running.
`timescale 1ns/10ps
`include "sicec_cfg.svh"
`define CHK(nm, x, g) begin check_count++; if ((g) !== (x)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, x, g); end end
`define WAITC(c, l) for (n = 0; n < (l) && !(c); n++) @(posedge ref_clk_i);
module testbench;
  import sicec_pkg::*;
  localparam logic [17:0] PAT = 18'h2d6b5;
  logic ref_clk_i = 0, reset_i = 1, xtal_clk_i = 0, ext_reset_i = 0, stop_exec_i = 0;
  logic insn_end_i = 0, soft_int_i = 0, break_req_i = 0, flag_clear_req_i = 0, por_pulse = 0;
  logic wb_we_i = 0, wb_stb_i = 0, wb_cyc_i = 0, mask_req = 1, int_ack_i, mask_bit_i, e;
  logic wb_ack_o, wb_err_o, bus_clk_en_o, clkgen_en_o, wdog_clk_o, int_take_o;
  logic stack_pc_minus1_o, break_state_o, flag_clear_allow_o;
  logic [17:0] src_req_i = '0, src_en_i = '0;
  logic [15:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic [4:0] vec_code_o;
  logic [7:0] dly = 8'h28;
  int miscompares = 0, check_count = 0, n, m, ticks = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;
  always #10 xtal_clk_i = ~xtal_clk_i;

  sicec_core i_dut (.ref_clk_i, .reset_i, .xtal_clk_i, .por_pulse_i(por_pulse), .ext_reset_i,
    .int_reset_i(1'b0), .wdog_service_i(1'b0), .stop_exec_i, .insn_end_i, .int_ack_i,
    .mask_bit_i, .soft_int_i, .break_req_i, .src_req_i, .src_en_i, .flag_clear_req_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i(4'h1), .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .bus_clk_en_o, .clkgen_en_o, .wdog_clk_o, .int_take_o,
    .vec_code_o, .stack_pc_minus1_o, .break_state_o, .flag_clear_allow_o);

  sicec_core_model i_core (.clk_i(ref_clk_i), .rst_i(reset_i), .take_i(int_take_o),
    .mask_req_i(mask_req), .dly_i(dly), .ack_o(int_ack_i), .mask_o(mask_bit_i));

  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge ref_clk_i);
    end while (!(wb_ack_o || wb_err_o));
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] x, input string nm);
    bus(a, 1'b0, 8'h00);
    `CHK(nm, {24'h000000, x}, q)
  endtask

  // Strobe pulse then two edges for the registered result
  task automatic pulse(input int which);
    if (which == 0) insn_end_i <= 1'b1; else soft_int_i <= 1'b1;
    @(posedge ref_clk_i);
    insn_end_i <= 1'b0;
    soft_int_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  task print_verdict;
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    ticks++;
    if (ticks == 90000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    `CHK("busclk_por", 1'b0, bus_clk_en_o)
    rd(`SICEC_ADR_PEND_LOW, 8'h00, "low_reset");
    bus(16'hfe0f, 1'b0, 8'h00);
    `CHK("unmapped_err", 1'b1, e)
    `WAITC(bus_clk_en_o, 20000)
    `CHK("por_delay", 1'b1, n > 16000 && n < 16800)
    for (int o = 1; o >= 0; o--) begin
      // Ends with the option cleared, as crystal systems should
      bus(`SICEC_ADR_OPTION, 1'b1, 8'(o));
      stop_exec_i <= 1'b1;
      @(posedge ref_clk_i);
      stop_exec_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      `CHK("stop_busclk", 1'b0, bus_clk_en_o)
      `CHK("stop_clkgen", 1'b0, clkgen_en_o)
      ext_reset_i <= 1'b1;
      @(posedge ref_clk_i);
      ext_reset_i <= 1'b0;
      `WAITC(bus_clk_en_o, 20000)
      m = (o == 1) ? 128 : 16384;
      `CHK("recovery", 1'b1, n + 16 > m && n < m + 16)
    end
    `WAITC(wdog_clk_o, 34000)
    `CHK("wdog_clock", 1'b1, wdog_clk_o)
    src_req_i <= PAT;
    @(posedge ref_clk_i);
    rd(`SICEC_ADR_PEND_LOW, {PAT[5:0], 2'b00}, "low");
    rd(`SICEC_ADR_PEND_MID, PAT[13:6], "mid");
    rd(`SICEC_ADR_PEND_HIGH, {4'h0, PAT[17:14]}, "high");
    bus(`SICEC_ADR_PEND_LOW, 1'b1, 8'hff);
    rd(`SICEC_ADR_PEND_LOW, {PAT[5:0], 2'b00}, "low_wr");
    `CHK("wr_take", 1'b0, int_take_o)
    src_req_i <= 18'h0000a;
    src_en_i <= '1;
    pulse(0);
    `CHK("masked", 1'b0, int_take_o)
    mask_req <= 1'b0;
    pulse(0);
    `CHK("vec_first", 5'h02, vec_code_o)
    `CHK("hw_pc", 1'b1, stack_pc_minus1_o)
    src_req_i <= 18'h0000b;
    pulse(0);
    `CHK("no_preempt", 5'h02, vec_code_o)
    `WAITC(!int_take_o, 100)
    pulse(0);
    `CHK("vec_next", 5'h01, vec_code_o)
    `WAITC(!int_take_o, 100)
    src_req_i <= '0;
    mask_req <= 1'b1;
    pulse(1);
    `CHK("soft_take", 1'b1, int_take_o)
    `CHK("soft_vec", `SICEC_VEC_SOFT, vec_code_o)
    `CHK("soft_pc", 1'b0, stack_pc_minus1_o)
    `WAITC(!int_take_o, 100)
    mask_req <= 1'b0;
    flag_clear_req_i <= 1'b1;
    break_req_i <= 1'b1;
    @(posedge ref_clk_i);
    break_req_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    `CHK("brk_state", 1'b1, break_state_o)
    `CHK("brk_vec", `SICEC_VEC_SOFT, vec_code_o)
    `CHK("brk_protect", 1'b0, flag_clear_allow_o)
    bus(`SICEC_ADR_BRK_CTRL, 1'b1, 8'h80);
    `CHK("brk_clear_en", 1'b1, flag_clear_allow_o)
    // Enable off again, so the check after break proves protection lifts
    bus(`SICEC_ADR_BRK_CTRL, 1'b1, 8'h00);
    `CHK("brk_reprotect", 1'b0, flag_clear_allow_o)
    `WAITC(!break_state_o, 200)
    `CHK("brk_left", 1'b0, break_state_o)
    `CHK("after_brk", 1'b1, flag_clear_allow_o)
    por_pulse <= 1'b1;
    @(posedge ref_clk_i);
    `CHK("por_clkgen", 1'b0, clkgen_en_o)
    por_pulse <= 1'b0;
    @(posedge ref_clk_i);
    `CHK("por_busclk", 1'b0, bus_clk_en_o)
    `CHK("por_clkgen_on", 1'b1, clkgen_en_o)
    print_verdict();
  end
endmodule // testbench
